// *** logic/lbsd_regs.svh ***
// Constants for the LCD backplane scan driver
`ifndef LBSD_REGS_SVH
`define LBSD_REGS_SVH
`define LBSD_NUM_COM        80
`define LBSD_MAX_MUX        146
`define LBSD_SYNC_STAGES    2
`define LBSD_LINE_CYC_US    61
`define LBSD_LINE_HIGH_US   61
`define LBSD_START_HIGH_US  122
`define LBSD_RST_SYNC_OUT   1'b0
`define LBSD_RST_CARRY      1'b0
`endif

// *** logic/lbsd_pkg.sv ***
// Types shared by the LCD backplane scan driver
package lbsd_pkg;
   typedef enum logic {
      SYNC_WAIT,
      SYNC_RUN
   } lbsd_sync_e;
endpackage : lbsd_pkg

// *** logic/lbsd_scan_driver.sv ***
// LCD backplane common-line scan driver
//
// Behaviour
// - Each falling edge of the line clock copies the scan start input into the first scan stage.
// - The sample walks 80 stages, one per line clock fall, then appears on the scan carry out.
// - Display off low drives the common outputs, display off high releases all of them.
// - With sync source select high the driver makes the alternation sync and drives the sync pin.
// - With sync source select low the sync pin is an input and its sync is taken from outside.
// - No common output is selected until the first alternation sync pulse is seen; scan stages and carry run from reset.
// - Each common output picks one of the external drive levels from its scan state.
// - Drivers chain to serve up to 146 common lines when 80 outputs are not enough.
`include "lbsd_regs.svh"

module lbsd_scan_driver #(
   parameter int NUM_COM = `LBSD_NUM_COM
) (
   input  wire logic               core_clk_i,
   input  wire logic               rst_n_i,
   input  wire logic               line_clk_i,
   input  wire logic               scan_start_in_i,
   input  wire logic               display_off_in_i,
   input  wire logic               sync_source_select_i,
   input  wire logic               sync_pin_i,
   output logic                    sync_pin_o,
   output logic                    sync_pin_oe_o,
   output logic                    scan_carry_out_o,
   output logic [NUM_COM-1:0]      com_sel_o,
   output logic                    com_pol_o,
   output logic                    com_oe_o,
   output lbsd_pkg::lbsd_sync_e    sync_state_o
);
   import lbsd_pkg::*;

   typedef struct packed {
      logic               lclk_s1;
      logic               lclk_s2;
      logic               lclk_s3;
      logic               start_s1;
      logic               start_s2;
      logic               display_off_in_s1;
      logic               display_off_in_s2;
      logic               msel_s1;
      logic               msel_s2;
      logic               min_s1;
      logic               min_s2;
      logic               min_s3;
      logic [NUM_COM-1:0] shift;
      logic               carry;
      logic               m_out;
      logic               m_oe;
      lbsd_sync_e         sync;
      logic [NUM_COM-1:0] com_sel;
      logic               com_pol;
      logic               com_oe;
   } lbsd_state_s;

   lbsd_state_s st_r;
   lbsd_state_s st_nxt;
   logic        fall;
   logic        m_rise;

   // Rising or falling edge between an older and a newer synchronised sample
   function automatic logic lbsd_edge(input logic older, input logic newer, input logic rising);
      return rising ? (~older & newer) : (older & ~newer);
   endfunction : lbsd_edge

   // Edge found from the second and third stages, never the first
   assign fall = lbsd_edge(st_r.lclk_s3, st_r.lclk_s2, 1'b0);

   always_comb begin
      st_nxt          = st_r;

      // Two flops on every pin before logic reads it; metastability stays in stage one
      st_nxt.lclk_s1  = line_clk_i;
      st_nxt.lclk_s2  = st_r.lclk_s1;
      st_nxt.lclk_s3  = st_r.lclk_s2;
      st_nxt.start_s1 = scan_start_in_i;
      st_nxt.start_s2 = st_r.start_s1;
      st_nxt.display_off_in_s1  = display_off_in_i;
      st_nxt.display_off_in_s2  = st_r.display_off_in_s1;
      st_nxt.msel_s1  = sync_source_select_i;
      st_nxt.msel_s2  = st_r.msel_s1;
      st_nxt.min_s1   = sync_pin_i;
      st_nxt.min_s2   = st_r.min_s1;
      st_nxt.min_s3   = st_r.min_s2;

      // Scan stages and carry move only on a line clock fall
      if (fall) begin
         st_nxt.shift = {st_r.shift[NUM_COM-2:0], st_r.start_s2};
         st_nxt.carry = st_r.shift[NUM_COM-1];
         // Master flips the sync once per frame, at the token's entry
         if (st_r.msel_s2 && st_r.start_s2 && !st_r.shift[0]) begin
            st_nxt.m_out = ~st_r.m_out;
         end
      end

      // Sync pin direction and the source of the alternation edge
      st_nxt.m_oe = st_r.msel_s2;
      m_rise = st_r.msel_s2 ? lbsd_edge(st_r.m_out, st_nxt.m_out, 1'b1)
                            : lbsd_edge(st_r.min_s3, st_r.min_s2, 1'b1);
      if (st_r.sync == SYNC_WAIT && m_rise) begin
         st_nxt.sync = SYNC_RUN;
      end

      // Levels seen by the external voltage switches
      // Before the first sync pulse every line sits at non-select, so no stray select reaches the glass
      st_nxt.com_sel = (st_r.sync == SYNC_RUN) ? st_r.shift : '0;
      st_nxt.com_pol = st_r.msel_s2 ? st_r.m_out : st_r.min_s2;
      st_nxt.com_oe  = ~st_r.display_off_in_s2;
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_r       <= '0;
         st_r.carry <= `LBSD_RST_CARRY;
         st_r.m_out <= `LBSD_RST_SYNC_OUT;
         st_r.sync  <= SYNC_WAIT;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sync_pin_o       = st_r.m_out;
   assign sync_pin_oe_o    = st_r.m_oe;
   assign scan_carry_out_o = st_r.carry;
   assign com_sel_o        = st_r.com_sel;
   assign com_pol_o        = st_r.com_pol;
   assign com_oe_o         = st_r.com_oe;
   assign sync_state_o     = st_r.sync;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   // Scan path
   AST_CAPTURE: assert property (fall |=> st_r.shift[0] == $past(st_r.start_s2))
      else $error("scan start not captured on line clock fall");

   AST_SHIFT: assert property (fall |=> st_r.shift[NUM_COM-1:1] == $past(st_r.shift[NUM_COM-2:0]))
      else $error("scan stages did not advance by one");

   AST_HOLD: assert property (!fall |=> $stable(st_r.shift))
      else $error("scan stages moved without a line clock fall");

   AST_CARRY: assert property (fall |=> scan_carry_out_o == $past(st_r.shift[NUM_COM-1]))
      else $error("carry out does not follow last stage");

   AST_CARRY_HOLD: assert property (!fall |=> $stable(scan_carry_out_o))
      else $error("carry out moved without a line clock fall");

   AST_CHAIN: assert property (fall && st_r.shift[NUM_COM-1] |=> scan_carry_out_o)
      else $error("token in last stage not passed to next driver");

   // Output enable
   AST_BLANK: assert property (st_r.display_off_in_s2 |=> !com_oe_o)
      else $error("common outputs driven while display off");

   AST_DRIVE: assert property (!st_r.display_off_in_s2 |=> com_oe_o)
      else $error("common outputs released while display on");

   // Sync pin, master and slave
   AST_MASTER: assert property (st_r.msel_s2 |=> sync_pin_oe_o)
      else $error("master does not drive sync pin");

   AST_SYNC_TOGGLE: assert property (fall && st_r.msel_s2 && st_r.start_s2 && !st_r.shift[0]
                                     |=> sync_pin_o != $past(sync_pin_o))
      else $error("master sync did not flip at token entry");

   AST_SYNC_STEADY: assert property (!(fall && st_r.start_s2 && !st_r.shift[0]) |=> $stable(sync_pin_o))
      else $error("master sync flipped away from token entry");

   AST_SLAVE: assert property (!st_r.msel_s2 |=> !sync_pin_oe_o ##0 com_pol_o == $past(st_r.min_s2))
      else $error("slave drives sync pin or ignores sync input");

   AST_SLAVE_QUIET: assert property (!st_r.msel_s2 |=> $stable(sync_pin_o))
      else $error("slave changed its own sync output");

   AST_SLAVE_SYNC: assert property (st_r.sync == SYNC_WAIT && !st_r.msel_s2 && st_r.min_s2 && !st_r.min_s3
                                    |=> sync_state_o == SYNC_RUN)
      else $error("slave missed the first sync rise");

   // Power-up synchronisation
   AST_NO_EARLY: assert property (st_r.sync == SYNC_WAIT |=> com_sel_o == '0)
      else $error("select level before first sync pulse");

   AST_SYNC_WAIT: assert property (st_r.sync == SYNC_WAIT && !m_rise |=> sync_state_o == SYNC_WAIT)
      else $error("synchronised without a sync pulse");

   AST_SYNC_STICKY: assert property (st_r.sync == SYNC_RUN |=> sync_state_o == SYNC_RUN)
      else $error("synchronisation lost after it began");

   // Drive levels
   AST_SELECT: assert property (st_r.sync == SYNC_RUN |=> com_sel_o == $past(st_r.shift))
      else $error("common select does not follow scan stage");

   AST_POL: assert property (st_r.msel_s2 |=> com_pol_o == $past(st_r.m_out))
      else $error("polarity does not follow own sync");

   COV_TOKEN: cover property (fall && st_r.start_s2);
   COV_BLANK: cover property ($fell(com_oe_o));
   COV_TOGGLE: cover property (st_r.msel_s2 ##1 $changed(sync_pin_o));
   COV_SYNCED: cover property (st_r.sync == SYNC_WAIT ##1 st_r.sync == SYNC_RUN);
   COV_CARRY: cover property ($rose(scan_carry_out_o));
endmodule : lbsd_scan_driver

// *** bench/lbsd_host_model.sv ***
// Host model: free running line clock and scan start pulses
module lbsd_host_model (
   input  wire logic core_clk_i,
   input  wire logic run_i,
   output logic      line_clk_o,
   output logic      scan_start_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int   seed = 57615;
   int   cnt = 0;
   logic hold = 1'b0;
   logic go;
   initial begin
      line_clk_o = 1'b1;
      scan_start_o = 1'b0;
   end
   always @(posedge core_clk_i) if (run_i) begin
      cnt <= (cnt + 1) % 6;
      if (cnt == 5) begin
         line_clk_o <= ~line_clk_o;
         // Start moves only at rises, so it is stable around every fall
         if (!line_clk_o) begin
            go = !hold && (($random(seed) & 15) == 0);
            scan_start_o <= hold || go;
            hold <= go;
         end
      end
   end
endmodule : lbsd_host_model

// *** bench/tb.sv ***
// Self-checking bench for the backplane scan driver
module tb;
   import lbsd_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int N = 8;
   logic clk = 0, rst_n = 0, run = 0, display_off_in = 0, msel = 0, s_in = 0;
   logic lclk, start, s_o, s_oe, car, pol, oe, car2;
   logic [N-1:0] sel, ev;
   lbsd_sync_e st;
   int miscompares = 0, tests_run = 0, cyc = 0, seed = 57615;
   int sh[N], sh2[N], mcar, m2, msync, mrun, ps;
   initial forever #2 clk = ~clk;
   lbsd_host_model HOST (.core_clk_i(clk), .run_i(run), .line_clk_o(lclk), .scan_start_o(start));
   lbsd_scan_driver #(.NUM_COM(N)) DUT (.core_clk_i(clk), .rst_n_i(rst_n), .line_clk_i(lclk),
      .scan_start_in_i(start), .display_off_in_i(display_off_in), .sync_source_select_i(msel), .sync_pin_i(s_in),
      .sync_pin_o(s_o), .sync_pin_oe_o(s_oe), .scan_carry_out_o(car), .com_sel_o(sel),
      .com_pol_o(pol), .com_oe_o(oe), .sync_state_o(st));
   // Second driver fed from the first one's carry, wired as a cascade
   lbsd_scan_driver #(.NUM_COM(N)) DUT2 (.core_clk_i(clk), .rst_n_i(rst_n), .line_clk_i(lclk),
      .scan_start_in_i(car), .display_off_in_i(display_off_in), .sync_source_select_i(1'b0), .sync_pin_i(s_in),
      .sync_pin_o(), .sync_pin_oe_o(), .scan_carry_out_o(car2), .com_sel_o(),
      .com_pol_o(), .com_oe_o(), .sync_state_o());
   task automatic chk(input logic [N-1:0] g, input logic [N-1:0] e);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : tally_and_finish
   always @(posedge clk) begin
      cyc++;
      if (cyc == 10000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   // Reference: one step per line clock fall, checked once outputs settle
   always @(negedge lclk) if (rst_n && run) begin
      m2 = sh2[N-1];
      for (int i = N - 1; i > 0; i--) sh2[i] = sh2[i-1];
      sh2[0] = mcar;
      mcar = sh[N-1];
      if (msel && start && sh[0] == 0) msync ^= 1;
      ps = msel ? msync : int'(s_in);
      if (ps == 1) mrun = 1;
      for (int i = N - 1; i > 0; i--) sh[i] = sh[i-1];
      sh[0] = start;
      for (int i = 0; i < N; i++) ev[i] = mrun && sh[i];
      repeat (7) @(posedge clk);
      #1;
      chk(car, mcar);
      chk(car2, m2);
      chk(sel, ev);
      chk(pol, ps);
      chk(oe, !display_off_in);
      chk(s_oe, msel);
      chk(msel ? s_o : 0, msel ? msync : 0);
      chk(st, mrun ? SYNC_RUN : SYNC_WAIT);
      @(posedge clk) display_off_in <= ($random(seed) & 3) == 0;
   end
   task automatic restart(input logic m);
      // Let the reference finish its checks and park the line clock high
      if (run) begin
         @(negedge lclk);
         repeat (10) @(posedge clk);
      end
      run <= 0;
      rst_n <= 0;
      s_in <= 0;
      repeat (20) @(posedge clk);
      foreach (sh[i]) sh[i] = 0;
      foreach (sh2[i]) sh2[i] = 0;
      mcar = 0;
      m2 = 0;
      msync = 0;
      mrun = 0;
      msel <= m;
      rst_n <= 1;
      run <= 1;
   endtask : restart
   initial begin
      restart(0);
      repeat (480) @(posedge clk);
      $display("slave wait done");
      // Raise the slave sync just after a line clock rise, clear of any fall
      @(posedge lclk) s_in <= 1;
      repeat (480) @(posedge clk);
      $display("slave run done");
      restart(1);
      repeat (3000) @(posedge clk);
      $display("master run done");
      tally_and_finish();
   end
endmodule : tb
